// >>> src/xcs_bridge.sv
// Functional notes
// - Up to four 8-bit peripherals, each spanning at most sixteen ports.
// - Mode 1: four selects, two address pins; mode 2: two selects, four.
// - Bit 0 of the selection register at 0xf0 picks the mode.
// - Each select compares the host address with its own base registers.
// - Mode 1 bases hold A15..A2; A1..A0 pass straight to the pins.
// - Mode 2 bases hold A15..A4; A3..A0 pass straight to the pins.
// - A select is low only during the host cycle that matches it.
// - Full 16-bit decode; with bit 6 of global_osc_config_reg set, address bits 15..12 must be zero.
// - Read and write strobes pulse only in a matching cycle.
// - Disable bit in each low base byte keeps that select idle.
// - Write-protect bit sets once; only hard reset clears it.
// - Protected select ignores writes to its high and low base bytes.
// - Strobe pulse width comes from a selection register field.
`timescale 1ns/1ps
`default_nettype none
module xcs_bridge (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        cfg_wr_en,
    input  wire logic        cfg_rd_en,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [7:0]  cfg_wdata,
    output logic      [7:0]  cfg_rdata,
    input  wire logic [7:0]  global_osc_config_reg,
    input  wire logic        io_start,
    input  wire logic        io_write,
    input  wire logic [15:0] io_addr,
    input  wire logic [7:0]  io_wdata,
    output logic             io_busy,
    output logic             io_done,
    output logic             io_hit,
    output logic      [7:0]  io_rdata,
    output logic             periph_select0_n,
    output logic             periph_select1_n,
    output logic             periph_select2_n,
    output logic             periph_select3_n,
    output logic             periph_addr_out0,
    output logic             periph_addr_out1,
    output logic             periph_addr_out2,
    output logic             periph_addr_out3,
    output logic             periph_read_strobe_n,
    output logic             periph_write_strobe_n,
    input  wire logic [7:0]  periph_data_in,
    output logic      [7:0]  periph_data_out,
    output logic             periph_data_oe
);
    localparam int NS = xcs_pkg::NUM_SEL;

    typedef struct packed {
        xcs_pkg::xcs_state_t  st;
        logic [1:0]           sel;
        logic [15:0]          addr;
        logic                 wr;
        logic [7:0]           wdata;
        logic [7:0]           rdata;
        logic [1:0]           cnt;
        logic                 done;
        logic                 hit;
        logic [7:0]           cfg_rdata;
        logic [7:0]           sel_cfg;
        logic [NS-1:0][7:0]   base_hi;
        logic [NS-1:0][7:0]   base_lo;
        logic [7:0]           din_s1;
        logic [7:0]           din_s2;
    } xcs_bridge_t;

    xcs_bridge_t r_r;
    xcs_bridge_t r_nxt;

    logic        strb_active;
    logic        strb_last;
    logic        mode2;
    logic        qual;
    logic        in_cycle;
    logic [NS-1:0] hit_vec;
    logic [NS-1:0] sel_low;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic xcs_match(
        input logic [15:0] a,
        input logic [7:0]  hi,
        input logic [7:0]  lo,
        input logic        m2,
        input logic        q,
        input int          idx
    );
        logic ok;
        ok = (a[15:8] == hi);
        if (m2)
            ok = ok && (a[7:4] == lo[7:4]) && (idx < 2);
        else
            ok = ok && (a[7:2] == lo[7:2]);
        if (q && (a[15:12] != 4'h0))
            ok = 1'b0;
        if (lo[xcs_pkg::DIS_BIT])
            ok = 1'b0;
        return ok;
    endfunction : xcs_match

    assign mode2 = r_r.sel_cfg[xcs_pkg::MODE_BIT];
    assign qual  = global_osc_config_reg[xcs_pkg::QUAL_BIT];

    always_comb
    begin
        hit_vec = '0;
        for (int i = 0; i < NS; i++)
            hit_vec[i] = xcs_match(io_addr, r_r.base_hi[i], r_r.base_lo[i], mode2, qual, i);
    end

    // ------------------------------------------------------------
    // Sequencer and configuration registers
    // ------------------------------------------------------------
    always_comb
    begin
        r_nxt        = r_r;
        r_nxt.done   = 1'b0;
        r_nxt.din_s1 = periph_data_in;
        r_nxt.din_s2 = r_r.din_s1;
        case (r_r.st)
            xcs_pkg::ST_IDLE:
            begin
                if (io_start)
                begin
                    r_nxt.addr  = io_addr;
                    r_nxt.wr    = io_write;
                    r_nxt.wdata = io_wdata;
                    r_nxt.hit   = |hit_vec;
                    if (|hit_vec)
                        r_nxt.st = xcs_pkg::ST_SETUP;
                    else
                        r_nxt.st = xcs_pkg::ST_DONE;
                    r_nxt.sel = 2'h0;
                    for (int i = NS - 1; i >= 0; i--)
                        if (hit_vec[i])
                            r_nxt.sel = 2'(i);
                end
            end
            xcs_pkg::ST_SETUP:
                r_nxt.st = xcs_pkg::ST_STROBE;
            xcs_pkg::ST_STROBE:
            begin
                if (strb_last)
                begin
                    r_nxt.st  = xcs_pkg::ST_HOLD;
                    r_nxt.cnt = xcs_pkg::HOLD_CYC - 2'h1;
                end
            end
            xcs_pkg::ST_HOLD:
            begin
                if (r_r.cnt == 2'h0)
                begin
                    r_nxt.st = xcs_pkg::ST_DONE;
                    if (!r_r.wr)
                        r_nxt.rdata = r_r.din_s2;
                end
                else
                    r_nxt.cnt = r_r.cnt - 2'h1;
            end
            xcs_pkg::ST_DONE:
            begin
                r_nxt.done = 1'b1;
                r_nxt.st   = xcs_pkg::ST_IDLE;
            end
            default:
                r_nxt.st = xcs_pkg::ST_IDLE;
        endcase

        if (cfg_wr_en)
        begin
            if (cfg_addr == xcs_pkg::SEL_CFG_OFS)
                r_nxt.sel_cfg = cfg_wdata;
            for (int i = 0; i < NS; i++)
            begin
                if (!r_r.base_lo[i][xcs_pkg::WP_BIT])
                begin
                    if (cfg_addr == xcs_pkg::BASE_HI_OFS0 + 8'(2 * i))
                        r_nxt.base_hi[i] = cfg_wdata;
                    if (cfg_addr == xcs_pkg::BASE_LO_OFS0 + 8'(2 * i))
                        r_nxt.base_lo[i] = cfg_wdata;
                end
            end
        end

        r_nxt.cfg_rdata = r_r.cfg_rdata;
        if (cfg_rd_en)
        begin
            r_nxt.cfg_rdata = 8'h00;
            if (cfg_addr == xcs_pkg::SEL_CFG_OFS)
                r_nxt.cfg_rdata = r_r.sel_cfg;
            for (int i = 0; i < NS; i++)
            begin
                if (cfg_addr == xcs_pkg::BASE_HI_OFS0 + 8'(2 * i))
                    r_nxt.cfg_rdata = r_r.base_hi[i];
                if (cfg_addr == xcs_pkg::BASE_LO_OFS0 + 8'(2 * i))
                    r_nxt.cfg_rdata = r_r.base_lo[i];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            r_r         <= '0;
            r_r.st      <= xcs_pkg::ST_IDLE;
            r_r.sel_cfg <= xcs_pkg::SEL_CFG_RST;
            for (int i = 0; i < NS; i++)
            begin
                r_r.base_hi[i] <= xcs_pkg::BASE_RST;
                r_r.base_lo[i] <= xcs_pkg::BASE_RST;
            end
        end
        else
            r_r <= r_nxt;
    end

    xcs_strobe_timer #(
        .WIDTH_W (xcs_pkg::WIDTH_W)
    ) u_strobe (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .start   (r_r.st == xcs_pkg::ST_SETUP),
        .width   (r_r.sel_cfg[xcs_pkg::WIDTH_LSB +: xcs_pkg::WIDTH_W]),
        .active  (strb_active),
        .last    (strb_last)
    );

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    assign in_cycle = (r_r.st == xcs_pkg::ST_SETUP) || (r_r.st == xcs_pkg::ST_STROBE)
                   || (r_r.st == xcs_pkg::ST_HOLD);

    always_comb
    begin
        for (int i = 0; i < NS; i++)
            sel_low[i] = in_cycle && (r_r.sel == 2'(i)) && !(mode2 && i >= 2);
    end

    assign periph_select0_n      = !sel_low[0];
    assign periph_select1_n      = !sel_low[1];
    assign periph_select2_n      = !sel_low[2];
    assign periph_select3_n      = !sel_low[3];
    assign periph_addr_out0      = r_r.addr[0];
    assign periph_addr_out1      = r_r.addr[1];
    assign periph_addr_out2      = mode2 && r_r.addr[2];
    assign periph_addr_out3      = mode2 && r_r.addr[3];
    assign periph_read_strobe_n  = !(strb_active && !r_r.wr);
    assign periph_write_strobe_n = !(strb_active && r_r.wr);
    assign periph_data_out       = r_r.wdata;
    assign periph_data_oe        = in_cycle && r_r.wr;
    assign io_busy               = r_r.st != xcs_pkg::ST_IDLE;
    assign io_done               = r_r.done;
    assign io_hit                = r_r.hit;
    assign io_rdata              = r_r.rdata;
    assign cfg_rdata             = r_r.cfg_rdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    logic [NS-1:0] wp_vec;
    always_comb
    begin
        for (int i = 0; i < NS; i++)
            wp_vec[i] = r_r.base_lo[i][xcs_pkg::WP_BIT];
    end

    sequence seq_rd_end;
        (r_r.st == xcs_pkg::ST_HOLD) && (r_r.cnt == 2'h0) && !r_r.wr;
    endsequence
    sequence seq_reply;
        (r_r.st == xcs_pkg::ST_DONE) ##1 io_done;
    endsequence

    a_sel_in_cycle: assert property ((sel_low != '0) |-> in_cycle && r_r.hit)
        else $error("select low outside a matching cycle");
    a_strobe_match: assert property (!(periph_read_strobe_n && periph_write_strobe_n)
        |-> (r_r.st == xcs_pkg::ST_STROBE) && r_r.hit)
        else $error("strobe outside a matching cycle");
    a_data_release: assert property (periph_data_oe |-> r_r.wr && in_cycle)
        else $error("data bus driven outside a write");
    a_wp_sticky: assert property ($past(reset_n) |-> ($past(wp_vec) & ~wp_vec) == '0)
        else $error("write protect bit cleared");
    a_wp_block: assert property (cfg_wr_en && wp_vec[1]
        |=> $stable(r_r.base_lo[1]) && $stable(r_r.base_hi[1]))
        else $error("protected base register changed");
    a_mode2_sel: assert property (mode2 |-> periph_select2_n && periph_select3_n)
        else $error("upper selects active in mode 2");
    a_addr_pass: assert property (in_cycle |-> periph_addr_out0 == r_r.addr[0]
        && periph_addr_out1 == r_r.addr[1])
        else $error("low address bits not passed through");
    a_upper_qual: assert property ((r_r.st == xcs_pkg::ST_IDLE) && io_start && qual
        && (io_addr[15:12] != 4'h0) |=> !io_hit ##1 io_done)
        else $error("upper nibble not qualified");
    a_disable_sel: assert property (r_r.base_lo[0][xcs_pkg::DIS_BIT]
        && (r_r.st == xcs_pkg::ST_IDLE) && io_start |=> r_r.sel != 2'h0 || !r_r.hit)
        else $error("disabled select matched");
    a_read_return: assert property (seq_rd_end ##1 seq_reply
        |-> io_rdata == $past(r_r.din_s2, 2))
        else $error("read data not returned");

endmodule : xcs_bridge
`default_nettype wire

// >>> src/xcs_pkg.sv
package xcs_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 100;
    localparam logic [1:0]  HOLD_CYC      = 2'h2;

    // ------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  SEL_CFG_OFS   = 8'hf0;
    localparam logic [7:0]  BASE_HI_OFS0  = 8'hf1;
    localparam logic [7:0]  BASE_LO_OFS0  = 8'hf2;
    localparam logic [7:0]  SEL_CFG_RST   = 8'h00;
    localparam logic [7:0]  BASE_RST      = 8'h00;
    localparam int          NUM_SEL       = 4;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          MODE_BIT      = 0;
    localparam int          WIDTH_LSB     = 1;
    localparam int          WIDTH_W       = 3;
    localparam int          DIS_BIT       = 0;
    localparam int          WP_BIT        = 1;
    localparam int          QUAL_BIT      = 6;

    // ------------------------------------------------------------
    // Cycle sequencer states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_SETUP  = 5'h02,
        ST_STROBE = 5'h04,
        ST_HOLD   = 5'h08,
        ST_DONE   = 5'h10
    } xcs_state_t;

endpackage : xcs_pkg

// >>> src/xcs_strobe_timer.sv
`timescale 1ns/1ps
`default_nettype none
module xcs_strobe_timer #(
    parameter int WIDTH_W = 3
) (
    input  wire logic               ref_clk,
    input  wire logic               reset_n,
    input  wire logic               start,
    input  wire logic [WIDTH_W-1:0] width,
    output logic                    active,
    output logic                    last
);
    typedef struct packed {
        logic               act;
        logic [WIDTH_W-1:0] cnt;
        logic [WIDTH_W:0]   run;
    } xcs_tmr_t;

    xcs_tmr_t r_r;
    xcs_tmr_t r_nxt;

    // ------------------------------------------------------------
    // Pulse is width+1 cycles long
    // ------------------------------------------------------------
    always_comb
    begin
        r_nxt = r_r;
        if (start)
        begin
            r_nxt.act = 1'b1;
            r_nxt.cnt = width;
            r_nxt.run = '0;
        end
        else if (r_r.act)
        begin
            r_nxt.run = r_r.run + 1'b1;
            if (r_r.cnt == '0)
                r_nxt.act = 1'b0;
            else
                r_nxt.cnt = r_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            r_r <= '0;
        else
            r_r <= r_nxt;
    end

    assign active = r_r.act;
    assign last   = r_r.act && (r_r.cnt == '0);

    logic [WIDTH_W-1:0] width_q;
    always_ff @(posedge ref_clk)
    begin
        if (start)
            width_q <= width;
    end

    a_width_count: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $fell(r_r.act) |-> (r_r.run == {1'b0, width_q} + 1'b1))
        else $error("strobe width differs from programmed field");

endmodule : xcs_strobe_timer
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        ref_clk = 0;
    logic        reset_n = 0;
    logic        cfg_wr_en = 0;
    logic        cfg_rd_en = 0;
    logic [7:0]  cfg_addr = 8'h00;
    logic [7:0]  cfg_wdata = 8'h00;
    logic [7:0]  global_osc_config_reg = 8'h40;
    logic        io_start = 0;
    logic        io_write = 0;
    logic [15:0] io_addr = 16'h0000;
    logic [7:0]  io_wdata = 8'h00;
    logic [7:0]  cfg_rdata, io_rdata, periph_data_in, periph_data_out;
    logic        io_busy, io_done, io_hit, periph_data_oe;
    logic        periph_select0_n, periph_select1_n, periph_select2_n, periph_select3_n;
    logic        periph_addr_out0, periph_addr_out1, periph_addr_out2, periph_addr_out3;
    logic        periph_read_strobe_n, periph_write_strobe_n;
    logic [3:0]  selm, a_seen;
    int          strb, oen, bad;
    int          fail_count = 0;
    int          tests_run = 0;
    wire [3:0]   sel = {periph_select3_n, periph_select2_n, periph_select1_n, periph_select0_n};
    wire [3:0]   ao = {periph_addr_out3, periph_addr_out2, periph_addr_out1, periph_addr_out0};

    always #(xcs_pkg::CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

    xcs_bridge dut_u (.ref_clk, .reset_n, .cfg_wr_en, .cfg_rd_en, .cfg_addr, .cfg_wdata,
        .cfg_rdata, .global_osc_config_reg, .io_start, .io_write, .io_addr, .io_wdata,
        .io_busy, .io_done, .io_hit, .io_rdata, .periph_select0_n, .periph_select1_n,
        .periph_select2_n, .periph_select3_n, .periph_addr_out0, .periph_addr_out1,
        .periph_addr_out2, .periph_addr_out3, .periph_read_strobe_n, .periph_write_strobe_n,
        .periph_data_in, .periph_data_out, .periph_data_oe);

    xcs_periph_model periph_u (.ref_clk(ref_clk), .sel_n(sel), .addr(ao),
        .rd_n(periph_read_strobe_n), .wr_n(periph_write_strobe_n), .oe(periph_data_oe),
        .dout(periph_data_out), .bus(periph_data_in));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic test_done;
        if (fail_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask : chk

    task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        cfg_wr_en = 1;
        cfg_addr = a;
        cfg_wdata = d;
        @(negedge ref_clk);
        cfg_wr_en = 0;
    endtask : cfg_wr

    task automatic cfg_rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(negedge ref_clk);
        cfg_rd_en = 1;
        cfg_addr = a;
        @(negedge ref_clk);
        cfg_rd_en = 0;
        chk(nm, 16'(e), 16'(cfg_rdata));
    endtask : cfg_rd

    // One host cycle; records selects, strobe cycles and data drive, then judges them
    task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
                        input logic [3:0] em, input int es);
        int n;
        @(negedge ref_clk);
        io_start = 1;
        io_write = w;
        io_addr = a;
        io_wdata = d;
        selm = 4'h0;
        strb = 0;
        oen = 0;
        bad = 0;
        n = 0;
        @(negedge ref_clk);
        io_start = 0;
        while (io_done !== 1'b1)
        begin
            selm |= ~sel;
            if (periph_read_strobe_n === 1'b0 || periph_write_strobe_n === 1'b0)
            begin
                strb++;
                a_seen = ao;
                if (sel === 4'hf || (w ? periph_read_strobe_n : periph_write_strobe_n) !== 1'b1)
                    bad++;
            end
            if (periph_data_oe === 1'b1)
                oen++;
            n++;
            if (n > 40)
            begin
                fail_count++;
                test_done();
            end
            @(negedge ref_clk);
        end
        chk("io_hit", 16'(em != 4'h0), 16'(io_hit));
        chk("selects", 16'(em), 16'(selm));
        chk("strobe cycles", 16'(es), 16'(strb));
        chk("misplaced strobe", 16'h0000, 16'(bad));
        chk("data drive", 16'(w && em != 4'h0), 16'(oen != 0));
    endtask : xfer

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic s_reset;
        cfg_rd(8'hf0, 8'h00, "sel cfg");
        cfg_rd(8'hf8, 8'h00, "base3 lo");
        cfg_rd(8'h10, 8'h00, "unmapped");
    endtask : s_reset

    task automatic s_mode1;
        for (int i = 0; i < 4; i++)
        begin
            cfg_wr(xcs_pkg::BASE_HI_OFS0 + 8'(2 * i), 8'h03);
            cfg_wr(xcs_pkg::BASE_LO_OFS0 + 8'(2 * i), 8'h40 + 8'(16 * i));
        end
        for (int i = 0; i < 4; i++)
        begin
            xfer(1, 16'h0340 + 16'(17 * i), 8'ha0 + 8'(i), 4'(1 << i), 1);
            chk("addr pins", 16'(i), 16'(a_seen));
            xfer(0, 16'h0340 + 16'(17 * i), 8'h00, 4'(1 << i), 1);
            chk("read byte", 16'h00a0 + 16'(i), 16'(io_rdata));
        end
    endtask : s_mode1

    task automatic s_nomatch;
        xfer(1, 16'h0380, 8'h11, 4'h0, 0);
        xfer(0, 16'h5340, 8'h00, 4'h0, 0);
        cfg_wr(8'hf7, 8'h53);
        xfer(1, 16'h5370, 8'h22, 4'h0, 0);
        global_osc_config_reg = 8'h00;
        xfer(1, 16'h5370, 8'h22, 4'h8, 1);
        global_osc_config_reg = 8'h40;
        cfg_wr(8'hf7, 8'h03);
    endtask : s_nomatch

    task automatic s_width;
        for (int w = 3; w < 8; w += 4)
        begin
            cfg_wr(8'hf0, 8'(w << 1));
            xfer(1, 16'h0340, 8'h5a, 4'h1, w + 1);
        end
        cfg_wr(8'hf0, 8'h00);
    endtask : s_width

    task automatic s_mode2;
        cfg_wr(8'hf0, 8'h01);
        cfg_wr(8'hf2, 8'h10);
        xfer(1, 16'h031b, 8'h3c, 4'h1, 1);
        chk("addr pins", 16'h000b, 16'(a_seen));
        xfer(1, 16'h0362, 8'h3c, 4'h0, 0);
        cfg_wr(8'hf0, 8'h00);
    endtask : s_mode2

    task automatic s_disable;
        cfg_wr(8'hf2, 8'h41);
        xfer(1, 16'h0340, 8'h77, 4'h0, 0);
    endtask : s_disable

    task automatic s_protect;
        cfg_wr(8'hf4, 8'h52);
        cfg_wr(8'hf3, 8'h07);
        cfg_wr(8'hf4, 8'h40);
        cfg_rd(8'hf3, 8'h03, "base1 hi");
        cfg_rd(8'hf4, 8'h52, "base1 lo");
        xfer(0, 16'h0351, 8'h00, 4'h2, 1);
        chk("read byte", 16'h00a1, 16'(io_rdata));
        @(negedge ref_clk);
        reset_n = 0;
        @(negedge ref_clk);
        reset_n = 1;
        cfg_rd(8'hf4, 8'h00, "base1 lo");
    endtask : s_protect

    initial
    begin
        repeat (5) @(negedge ref_clk);
        reset_n = 1;
        s_reset();
        s_mode1();
        s_nomatch();
        s_width();
        s_mode2();
        s_disable();
        s_protect();
        test_done();
    end
endmodule : tb_top
`default_nettype wire

// >>> tb/xcs_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module xcs_periph_model (
    input  wire logic       ref_clk,
    input  wire logic [3:0] sel_n,
    input  wire logic [3:0] addr,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       oe,
    input  wire logic [7:0] dout,
    output logic      [7:0] bus
);
    // ------------------------------------------------------------
    // Four byte-wide peripherals, sixteen ports each
    // ------------------------------------------------------------
    logic [7:0] mem [4][16];
    logic [7:0] last_r = 8'h5a;
    logic [1:0] idx;

    always_comb
    begin
        idx = sel_n[0] ? (sel_n[1] ? (sel_n[2] ? 2'h3 : 2'h2) : 2'h1) : 2'h0;
    end

    // Released bus shows a changing pattern, never the old byte
    assign bus = oe ? dout : (!rd_n && sel_n != 4'hf) ? mem[idx][addr] : ~last_r;

    always_ff @(posedge ref_clk)
    begin
        last_r <= bus;
        if (!wr_n && sel_n != 4'hf)
            mem[idx][addr] <= bus;
    end
endmodule : xcs_periph_model
`default_nettype wire
